// ### sdec_consts.vh
// constants for the dual element control block: mode bit, register codes
// assumes the sequencer presents decoded move/exchange requests each cycle
`ifndef SDEC_CONSTS_VH
`define SDEC_CONSTS_VH
`define SDEC_MODE_DUAL_BIT 21
`define SDEC_MODE_LO_ALT_BIT 10
`define SDEC_MODE_HI_ALT_BIT 7
`define SDEC_MODE_RST 32'h0000_0000
`define SDEC_DW 40
`define SDEC_HIDDEN_W 16
`define SDEC_ENABLE_DELAY 1
// 7-bit universal code: 00_xxxxx data regs (bit4 = secondary file)
`define SDEC_CLS_DATA 2'h0
`define SDEC_CLS_CTRL 2'h1
`define SDEC_SEL_ARITH_P 7'h40
`define SDEC_SEL_ARITH_S 7'h41
`define SDEC_SEL_STICKY_P 7'h42
`define SDEC_SEL_STICKY_S 7'h43
`define SDEC_SEL_USER_STATUS_ONE 7'h44
`define SDEC_SEL_USER_STATUS_TWO 7'h45
`define SDEC_SEL_USER_STATUS_THREE 7'h46
`define SDEC_SEL_USER_STATUS_FOUR 7'h47
`define SDEC_SEL_BUSX1 7'h48
`define SDEC_SEL_BUSX2 7'h49
`define SDEC_SEL_MODE 7'h4a
`define SDEC_SEL_NONE 7'h7f
`define SDEC_OP_MOVE 2'h1
`define SDEC_OP_SWAP 2'h2
`endif

// ### sdec_ctrl_model.sv
// far side: control register bank and secondary multiplier results
// assumes control writes from the block are one-cycle strobes
`timescale 1ns/10ps
module sdec_ctrl_model (
   // clock and reset
   input wire clk,
   input wire rst_n,
   // control writes from the block
   input wire we,
   input wire [6:0] wsel,
   input wire [39:0] wdata,
   input wire cpl_we,
   input wire [6:0] cpl_wsel,
   input wire [39:0] cpl_wdata,
   // source read, same cycle as the request
   input wire [6:0] rsel,
   output logic [39:0] rdata,
   output logic [39:0] rdata_cpl,
   output logic [39:0] mult_fg,
   output logic [39:0] mult_bg
);
   logic [39:0] bank_ff [0:127];
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 128; i++)
            bank_ff[i] <= {5{i[7:0]}} ^ 40'h5a_a5c3_3c96;
      end else begin
         if (we)
            bank_ff[wsel] <= wdata;
         if (cpl_we)
            bank_ff[cpl_wsel] <= cpl_wdata;
      end
   end
   // a data-register source leaves the bus undriven: show inverted junk
   assign rdata = rsel[6] ? bank_ff[rsel] : ~bank_ff[rsel];
   // codes below 4a read code xor 1, so paired codes read their partner; others are shared
   assign rdata_cpl = rsel < 7'h4a ? bank_ff[rsel ^ 7'h01] : rdata;
   assign mult_fg = bank_ff[7'h7c];
   assign mult_bg = bank_ff[7'h7d];
endmodule // sdec_ctrl_model

// ### sdec_dual_ctrl.v
// dual element control: mode register, register pairing and move routing
// assumes sequencer issues decoded moves; condition results come per element
`timescale 1ns/10ps
`include "sdec_consts.vh"
module sdec_dual_ctrl (
   // clock and reset
   input wire CORE_CLK,
   input wire RST_N,
   // mode register write
   input wire MODE_WE,
   input wire [31:0] MODE_WDATA,
   // move or exchange request
   input wire [1:0] OP,
   input wire [6:0] DST_SEL,
   input wire [6:0] SRC_SEL,
   input wire COND_EN,
   input wire COND_PRIMARY,
   input wire COND_SECONDARY,
   // compute operand request from sequencer
   input wire [3:0] OPND_SEL,
   // control register source data from address generators
   input wire [`SDEC_DW-1:0] CTRL_RDATA,
   input wire [`SDEC_DW-1:0] CTRL_RDATA_CPL,
   // multiplier result-transfer read of secondary results
   input wire MULT_XFER,
   input wire MULT_XFER_BG,
   input wire [`SDEC_DW-1:0] MULT_FG_SECONDARY,
   input wire [`SDEC_DW-1:0] MULT_BG_SECONDARY,
   // mode status
   output wire [31:0] MODE_RDATA,
   output wire DUAL_ACTIVE,
   // control register writes, explicit and complement
   output reg CTRL_WE,
   output reg [6:0] CTRL_WSEL,
   output reg [`SDEC_DW-1:0] CTRL_WDATA,
   output reg CTRL_CPL_WE,
   output reg [6:0] CTRL_CPL_WSEL,
   output reg [`SDEC_DW-1:0] CTRL_CPL_WDATA,
   // operands for each element
   output wire [`SDEC_DW-1:0] OPND_PRIMARY,
   output wire [`SDEC_DW-1:0] OPND_SECONDARY,
   // transfer bus usage
   output reg DM_BUS_BUSY,
   output reg HIDDEN_BUS_BUSY,
   output wire PM_BUS_BUSY,
   output reg [`SDEC_DW-1:0] MULT_XFER_DATA
);
   reg [31:0] mode_ff;
   reg dual_ff;
   reg pend_valid_ff;
   reg pend_we_p;
   reg pend_we_s;
   reg [3:0] pend_wa_p;
   reg [3:0] pend_wa_s;
   reg pend_src_p_sec;
   reg pend_src_s_sec;
   reg [6:0] cw_sel_ff;
   reg [`SDEC_DW-1:0] cw_data_ff;
   // complement source is captured only; one value feeds both elements
   reg [`SDEC_DW-1:0] cw_data_cpl_ff;
   reg cw_ctrl_en_ff;
   reg cw_cpl_en_ff;
   reg [`SDEC_DW-1:0] nxt_xfer;

   wire alt_lo = mode_ff[`SDEC_MODE_LO_ALT_BIT];
   wire alt_hi = mode_ff[`SDEC_MODE_HI_ALT_BIT];

   // complement of a universal code; unlisted codes map to themselves
   function [6:0] cpl;
      input [6:0] s;
      begin
         if (s[6:5] == `SDEC_CLS_DATA) begin
            cpl = {s[6:5], ~s[4], s[3:0]};
         end else begin
            case (s)
               `SDEC_SEL_ARITH_P: cpl = `SDEC_SEL_ARITH_S;
               `SDEC_SEL_ARITH_S: cpl = `SDEC_SEL_ARITH_P;
               `SDEC_SEL_STICKY_P: cpl = `SDEC_SEL_STICKY_S;
               `SDEC_SEL_STICKY_S: cpl = `SDEC_SEL_STICKY_P;
               `SDEC_SEL_USER_STATUS_ONE: cpl = `SDEC_SEL_USER_STATUS_TWO;
               `SDEC_SEL_USER_STATUS_TWO: cpl = `SDEC_SEL_USER_STATUS_ONE;
               `SDEC_SEL_USER_STATUS_THREE: cpl = `SDEC_SEL_USER_STATUS_FOUR;
               `SDEC_SEL_USER_STATUS_FOUR: cpl = `SDEC_SEL_USER_STATUS_THREE;
               `SDEC_SEL_BUSX1: cpl = `SDEC_SEL_BUSX2;
               `SDEC_SEL_BUSX2: cpl = `SDEC_SEL_BUSX1;
               default: cpl = s;
            endcase
         end
      end
   endfunction

   function is_data;
      input [6:0] s;
      begin
         is_data = (s[6:5] == `SDEC_CLS_DATA);
      end
   endfunction

   // a half runs when the op is unconditional or its element's test passed
   function go;
      input cond_en;
      input cond_res;
      begin
         go = !cond_en || cond_res;
      end
   endfunction

   // mode register; the dual bit reaches execution one cycle later
   // bank select bits act at once; code leaves a gap before using them
   always @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         mode_ff <= `SDEC_MODE_RST;
         dual_ff <= 1'b0;
      end else begin
         if (MODE_WE) begin
            mode_ff <= MODE_WDATA;
         end
         dual_ff <= mode_ff[`SDEC_MODE_DUAL_BIT];
      end
   end
   assign MODE_RDATA = mode_ff;
   assign DUAL_ACTIVE = dual_ff;

   // element file write plan for this request
   reg px_we;
   reg sx_we;
   reg ctl_we;
   reg ctl_cpl_we;
   reg sx_src_cpl;
   reg [3:0] px_wa;
   reg [3:0] sx_wa;
   reg px_src_sec;
   reg sx_src_sec;
   reg [3:0] px_ra;
   reg [3:0] sx_ra;
   reg ok_p;
   reg ok_s;
   reg d_is_data;
   reg s_is_data;
   reg has_cpl;

   always @* begin
      px_we = 1'b0;
      sx_we = 1'b0;
      px_wa = 4'h0;
      sx_wa = 4'h0;
      px_src_sec = 1'b0;
      sx_src_sec = 1'b0;
      px_ra = 4'h0;
      sx_ra = 4'h0;
      ctl_we = 1'b0;
      ctl_cpl_we = 1'b0;
      sx_src_cpl = 1'b0;
      d_is_data = is_data(DST_SEL);
      s_is_data = is_data(SRC_SEL);
      has_cpl = (cpl(DST_SEL) != DST_SEL);
      // single mode: primary flags gate whole op
      ok_p = go(COND_EN, COND_PRIMARY);
      ok_s = dual_ff ? go(COND_EN, COND_SECONDARY) : ok_p;
      // "p" slot = explicit destination file, "s" slot = implicit one
      if (OP == `SDEC_OP_SWAP && d_is_data && s_is_data &&
          DST_SEL[4] != SRC_SEL[4]) begin
         // single 40-bit exchange, same in both modes when unconditional
         px_we = ok_p;
         px_wa = DST_SEL[3:0];
         px_src_sec = SRC_SEL[4];
         px_ra = SRC_SEL[3:0];
         sx_we = ok_s;
         sx_wa = SRC_SEL[3:0];
         sx_src_sec = DST_SEL[4];
         sx_ra = DST_SEL[3:0];
         sx_src_cpl = SRC_SEL[4]; // marks which file slot s writes
      end else if (OP == `SDEC_OP_MOVE && d_is_data && s_is_data) begin
         px_we = ok_p;
         px_wa = DST_SEL[3:0];
         px_src_sec = SRC_SEL[4];
         px_ra = SRC_SEL[3:0];
         sx_src_cpl = ~DST_SEL[4];
         if (dual_ff) begin
            sx_we = ok_s;
            sx_wa = DST_SEL[3:0];
            sx_src_sec = ~SRC_SEL[4];
            sx_ra = SRC_SEL[3:0];
         end
      end else if (OP == `SDEC_OP_MOVE && d_is_data) begin
         px_we = ok_p;
         px_wa = DST_SEL[3:0];
         sx_src_cpl = ~DST_SEL[4];
         if (dual_ff) begin
            sx_we = ok_s;
            sx_wa = DST_SEL[3:0];
         end
      end else if (OP == `SDEC_OP_MOVE && s_is_data) begin
         ctl_we = ok_p;
         px_ra = SRC_SEL[3:0];
         px_src_sec = SRC_SEL[4];
         sx_ra = SRC_SEL[3:0];
         sx_src_sec = ~SRC_SEL[4];
         if (dual_ff && has_cpl) begin
            ctl_cpl_we = ok_s;
         end // no complement: explicit only
      end else if (OP == `SDEC_OP_MOVE) begin
         ctl_we = ok_p;
      end
   end

   // two-stage: read in cycle of request, write back one cycle later
   reg dst_sec_ff;
   reg slot_s_sec_ff;
   reg src_ctrl_ff;
   always @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         pend_valid_ff <= 1'b0;
         pend_we_p <= 1'b0;
         pend_we_s <= 1'b0;
         pend_wa_p <= 4'h0;
         pend_wa_s <= 4'h0;
         pend_src_p_sec <= 1'b0;
         pend_src_s_sec <= 1'b0;
         dst_sec_ff <= 1'b0;
         slot_s_sec_ff <= 1'b0;
         src_ctrl_ff <= 1'b0;
         cw_ctrl_en_ff <= 1'b0;
         cw_cpl_en_ff <= 1'b0;
         cw_sel_ff <= `SDEC_SEL_NONE;
         cw_data_ff <= {`SDEC_DW{1'b0}};
         cw_data_cpl_ff <= {`SDEC_DW{1'b0}};
      end else begin
         pend_valid_ff <= (OP != 2'h0);
         pend_we_p <= px_we;
         pend_we_s <= sx_we;
         pend_wa_p <= px_wa;
         pend_wa_s <= sx_wa;
         pend_src_p_sec <= px_src_sec;
         pend_src_s_sec <= sx_src_sec;
         dst_sec_ff <= DST_SEL[4];
         slot_s_sec_ff <= sx_src_cpl;
         src_ctrl_ff <= !s_is_data;
         cw_ctrl_en_ff <= ctl_we;
         cw_cpl_en_ff <= ctl_cpl_we;
         cw_sel_ff <= DST_SEL;
         cw_data_ff <= CTRL_RDATA;
         cw_data_cpl_ff <= CTRL_RDATA_CPL;
      end
   end

   wire [`SDEC_DW-1:0] prd_a;
   wire [`SDEC_DW-1:0] prd_b;
   wire [`SDEC_DW-1:0] srd_a;
   wire [`SDEC_DW-1:0] srd_b;
   // the files are read for the move only when a move or exchange takes a data source
   wire file_rd = (OP != 2'h0) && is_data(SRC_SEL);
   // each file reads: port a for explicit source, port b for implicit;
   // a port that the move leaves free serves the compute operand index
   wire [3:0] pf_ra_a = (file_rd && !px_src_sec) ? px_ra : OPND_SEL;
   wire [3:0] pf_ra_b = (file_rd && !sx_src_sec) ? sx_ra : OPND_SEL;
   wire [3:0] sf_ra_a = (file_rd && px_src_sec) ? px_ra : OPND_SEL;
   wire [3:0] sf_ra_b = (file_rd && sx_src_sec) ? sx_ra : OPND_SEL;

   // values sourced from file selection of each slot
   wire [`SDEC_DW-1:0] val_p = pend_src_p_sec ? srd_a : prd_a;
   wire [`SDEC_DW-1:0] val_s = pend_src_s_sec ? srd_b : prd_b;
   wire [`SDEC_DW-1:0] wv_p = src_ctrl_ff ? cw_data_ff : val_p;
   wire [`SDEC_DW-1:0] wv_s = src_ctrl_ff ? cw_data_ff : val_s;
   wire p_to_sec = dst_sec_ff;
   wire s_to_sec = slot_s_sec_ff;

   // file writes: explicit lands in its file, implicit in the other
   wire pf_we_a = pend_we_p && !p_to_sec;
   wire sf_we_a = pend_we_p && p_to_sec;
   wire pf_we_b = pend_we_s && !s_to_sec;
   wire sf_we_b = pend_we_s && s_to_sec;

   // the same primary/alternate bits drive both files in parallel
   sdec_regfile u_primary (
      .CORE_CLK(CORE_CLK),
      .RST_N(RST_N),
      .alt_lo(alt_lo),
      .alt_hi(alt_hi),
      .we_a(pf_we_a),
      .wa_a(pend_wa_p),
      .wd_a(wv_p),
      .we_b(pf_we_b),
      .wa_b(pend_wa_s),
      .wd_b(wv_s),
      .ra_a(pf_ra_a),
      .ra_b(pf_ra_b),
      .rd_a_ff(prd_a),
      .rd_b_ff(prd_b)
   );
   sdec_regfile u_secondary (
      .CORE_CLK(CORE_CLK),
      .RST_N(RST_N),
      .alt_lo(alt_lo),
      .alt_hi(alt_hi),
      .we_a(sf_we_a),
      .wa_a(pend_wa_p),
      .wd_a(wv_p),
      .we_b(sf_we_b),
      .wa_b(pend_wa_s),
      .wd_b(wv_s),
      .ra_a(sf_ra_a),
      .ra_b(sf_ra_b),
      .rd_a_ff(srd_a),
      .rd_b_ff(srd_b)
   );

   // operand data: same register index in each element, one cycle later;
   // in the cycle after a move the operand of the explicit source's file shows the move's read instead
   assign OPND_PRIMARY = prd_a;
   assign OPND_SECONDARY = srd_a;

   // control register writes one cycle after request
   // each half of a split conditional has a strobe of its own
   always @* begin
      CTRL_WE = cw_ctrl_en_ff;
      CTRL_WSEL = cw_sel_ff;
      CTRL_WDATA = src_ctrl_ff ? cw_data_ff : val_p;
      CTRL_CPL_WE = cw_cpl_en_ff;
      CTRL_CPL_WSEL = cpl(cw_sel_ff);
      CTRL_CPL_WDATA = val_s;
   end

   // inter-element traffic only on data bus and hidden path
   // explicit half rides the data bus, implicit half of a data-register write the hidden path
   always @* begin
      DM_BUS_BUSY = pend_valid_ff && (pend_we_p || cw_ctrl_en_ff);
      HIDDEN_BUS_BUSY = pend_valid_ff && pend_we_s;
   end
   assign PM_BUS_BUSY = 1'b0;

   // secondary multiplier results reachable only through result transfer
   // they have no selector code, so no move or exchange can name them
   always @* begin
      nxt_xfer = MULT_XFER_BG ? MULT_BG_SECONDARY : MULT_FG_SECONDARY;
   end
   always @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         MULT_XFER_DATA <= {`SDEC_DW{1'b0}};
      end else if (MULT_XFER) begin
         MULT_XFER_DATA <= nxt_xfer;
      end
   end
endmodule // sdec_dual_ctrl

// ### sdec_dual_ctrl_properties.sv
// checker on the dual element control ports
// assumes one core clock and the active-low reset
`timescale 1ns/10ps
`include "sdec_consts.vh"
module sdec_dual_ctrl_props (
   // clock and reset
   input wire CORE_CLK,
   input wire RST_N,
   // requests
   input wire MODE_WE,
   input wire [31:0] MODE_WDATA,
   input wire [1:0] OP,
   input wire [6:0] DST_SEL,
   input wire [6:0] SRC_SEL,
   input wire COND_EN,
   input wire COND_PRIMARY,
   input wire COND_SECONDARY,
   input wire MULT_XFER,
   input wire MULT_XFER_BG,
   input wire [`SDEC_DW-1:0] MULT_FG_SECONDARY,
   input wire [`SDEC_DW-1:0] MULT_BG_SECONDARY,
   // results
   input wire [31:0] MODE_RDATA,
   input wire DUAL_ACTIVE,
   input wire CTRL_WE,
   input wire [6:0] CTRL_WSEL,
   input wire CTRL_CPL_WE,
   input wire [6:0] CTRL_CPL_WSEL,
   input wire DM_BUS_BUSY,
   input wire PM_BUS_BUSY,
   input wire [`SDEC_DW-1:0] MULT_XFER_DATA
);
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);
   wire mv = OP == `SDEC_OP_MOVE;
   wire pgo = !COND_EN || COND_PRIMARY;
   wire sgo = !COND_EN || COND_SECONDARY;
   wire sdat = SRC_SEL[6:5] == 2'b00;
   wire ddat = DST_SEL[6:5] == 2'b00;
   wire ctl = mv && DST_SEL[6] && DST_SEL != `SDEC_SEL_NONE;
   wire cpl = DST_SEL >= 7'h40 && DST_SEL <= 7'h49;
   a_mode_write: assert property (
      MODE_WE |=> MODE_RDATA == $past(MODE_WDATA))
      else $error("mode write lost");
   a_dual_delay: assert property (
      MODE_WE |=> ##1 DUAL_ACTIVE == $past(MODE_WDATA[21], 2))
      else $error("dual enable late or early");
   a_dual_follow: assert property (
      $stable(MODE_RDATA[21]) ##1 $stable(MODE_RDATA[21])
      |-> DUAL_ACTIVE == MODE_RDATA[21])
      else $error("dual state differs from mode bit");
   a_expl_write: assert property (
      ctl && pgo |=> CTRL_WE && CTRL_WSEL == $past(DST_SEL))
      else $error("explicit control write missing");
   a_cond_drop: assert property (
      mv && COND_EN && !COND_PRIMARY |=> !CTRL_WE)
      else $error("false condition still wrote");
   a_single_cpl: assert property (
      !DUAL_ACTIVE && OP != 2'h0 |=> !CTRL_CPL_WE)
      else $error("single mode duplicated a move");
   a_cpl_write: assert property (
      DUAL_ACTIVE && ctl && cpl && sdat && !DST_SEL[0] && sgo
      |=> CTRL_CPL_WE && CTRL_CPL_WSEL == $past(DST_SEL) + 7'h01)
      else $error("complement write missing");
   a_no_cpl: assert property (
      mv && DST_SEL[6] && (!cpl || !sdat) |=> !CTRL_CPL_WE)
      else $error("complement write without partner");
   a_mult_xfer: assert property (
      MULT_XFER |=> MULT_XFER_DATA ==
      $past(MULT_XFER_BG ? MULT_BG_SECONDARY : MULT_FG_SECONDARY))
      else $error("result transfer wrong");
   a_dm_used: assert property (
      (mv || OP == `SDEC_OP_SWAP) && sdat && ddat &&
      DST_SEL[4] != SRC_SEL[4] && pgo
      |=> DM_BUS_BUSY && !PM_BUS_BUSY)
      else $error("cross element move bus use wrong");
   c_swap: cover property (DUAL_ACTIVE && OP == `SDEC_OP_SWAP);
   c_cpl: cover property (CTRL_CPL_WE);
   c_split: cover property (DUAL_ACTIVE && mv && COND_EN
      && COND_PRIMARY != COND_SECONDARY);
endmodule // sdec_dual_ctrl_props

bind sdec_dual_ctrl sdec_dual_ctrl_props u_props (
   .CORE_CLK(CORE_CLK), .RST_N(RST_N), .MODE_WE(MODE_WE),
   .MODE_WDATA(MODE_WDATA), .OP(OP), .DST_SEL(DST_SEL), .SRC_SEL(SRC_SEL),
   .COND_EN(COND_EN), .COND_PRIMARY(COND_PRIMARY),
   .COND_SECONDARY(COND_SECONDARY), .MULT_XFER(MULT_XFER),
   .MULT_XFER_BG(MULT_XFER_BG), .MULT_FG_SECONDARY(MULT_FG_SECONDARY),
   .MULT_BG_SECONDARY(MULT_BG_SECONDARY), .MODE_RDATA(MODE_RDATA),
   .DUAL_ACTIVE(DUAL_ACTIVE), .CTRL_WE(CTRL_WE), .CTRL_WSEL(CTRL_WSEL),
   .CTRL_CPL_WE(CTRL_CPL_WE), .CTRL_CPL_WSEL(CTRL_CPL_WSEL),
   .DM_BUS_BUSY(DM_BUS_BUSY), .PM_BUS_BUSY(PM_BUS_BUSY),
   .MULT_XFER_DATA(MULT_XFER_DATA));

// ### sdec_dual_ctrl_test.sv
// self-checking bench for the dual element control block
// assumes the control bank model on the far side
`timescale 1ns/10ps
`include "sdec_consts.vh"
module sdec_dual_ctrl_test;
   logic clk, rst_n, mode_we, ce, cp, cs, mx, mxbg, dm, sw;
   logic [31:0] mode_wd, mode_rd;
   logic [1:0] op;
   logic [6:0] dst, src, cwsel, pwsel;
   logic [3:0] osel;
   logic [39:0] crd, crdc, mfg, mbg, cwd, pwd, op_p, op_s, mxd;
   logic dual, cwe, pwe, dmb, hb, pmb, alt;
   logic [39:0] r [0:15];
   logic [39:0] s [0:15];
   logic [39:0] c [0:127];
   logic [15:0] lf;
   int error_cnt = 0;
   int compares = 0;
   int cyc = 0;
   sdec_dual_ctrl u_dut (
      .CORE_CLK(clk), .RST_N(rst_n), .MODE_WE(mode_we),
      .MODE_WDATA(mode_wd), .OP(op), .DST_SEL(dst), .SRC_SEL(src),
      .COND_EN(ce), .COND_PRIMARY(cp), .COND_SECONDARY(cs),
      .OPND_SEL(osel), .CTRL_RDATA(crd), .CTRL_RDATA_CPL(crdc),
      .MULT_XFER(mx), .MULT_XFER_BG(mxbg), .MULT_FG_SECONDARY(mfg),
      .MULT_BG_SECONDARY(mbg), .MODE_RDATA(mode_rd), .DUAL_ACTIVE(dual),
      .CTRL_WE(cwe), .CTRL_WSEL(cwsel), .CTRL_WDATA(cwd),
      .CTRL_CPL_WE(pwe), .CTRL_CPL_WSEL(pwsel), .CTRL_CPL_WDATA(pwd),
      .OPND_PRIMARY(op_p), .OPND_SECONDARY(op_s), .DM_BUS_BUSY(dmb),
      .HIDDEN_BUS_BUSY(hb), .PM_BUS_BUSY(pmb), .MULT_XFER_DATA(mxd));
   sdec_ctrl_model u_src (
      .clk(clk), .rst_n(rst_n), .we(cwe), .wsel(cwsel), .wdata(cwd),
      .cpl_we(pwe), .cpl_wsel(pwsel), .cpl_wdata(pwd), .rsel(src),
      .rdata(crd), .rdata_cpl(crdc), .mult_fg(mfg), .mult_bg(mbg));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // a hang costs one mismatch and ends the run
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         test_done;
      end
   end
   function automatic logic [15:0] lfsr(input logic [15:0] v);
      lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   function automatic logic [39:0] rv(input logic [6:0] x);
      rv = x[6:5] != 2'b00 ? c[x] : x[4] ? s[x[3:0]] : r[x[3:0]];
   endfunction
   task automatic wv(input logic [6:0] x, input logic [39:0] v);
      if (x[6:5] != 2'b00)
         c[x] = v;
      else if (x[4])
         s[x[3:0]] = v;
      else
         r[x[3:0]] = v;
   endtask
   task automatic chk(input string n, input logic [47:0] got, exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", n, exp, got);
      end
   endtask
   task automatic test_done;
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // model the move first, so both halves see the old values
   task automatic op_do(input logic [1:0] o, input logic [6:0] d, sr,
         input logic e, p, q);
      logic [6:0] di;
      logic [39:0] va, vb;
      logic ge, gi, dd, sd, imp;
      dd = d[6:5] == 2'b00;
      sd = sr[6:5] == 2'b00;
      ge = !e || p;
      gi = dm ? !e || q : ge;
      va = rv(sr);
      vb = o == 2'h2 ? rv(d) : sd ? rv(sr ^ 7'h10) : va;
      di = o == 2'h2 ? sr : dd ? d ^ 7'h10 : d ^ 7'h01;
      imp = o == 2'h2 || dm && (dd || sd && d >= 7'h40 && d <= 7'h49);
      if (ge)
         wv(d, va);
      if (imp && gi)
         wv(di, vb);
      @(posedge clk);
      op <= o;
      dst <= d;
      src <= sr;
      ce <= e;
      cp <= p;
      cs <= q;
      @(posedge clk);
      op <= 2'h0;
      #1;
      chk("ctrl_we", cwe, !dd && ge);
      if (!dd && ge)
         chk("ctrl_w", {cwsel, cwd}, {d, va});
      chk("cpl_we", pwe, !dd && imp && gi);
      if (!dd && imp && gi)
         chk("cpl_w", {pwsel, pwd}, {di, vb});
      chk("bus", {dmb, hb, pmb}, {ge, dd && imp && gi, 1'b0});
   endtask
   task automatic verify;
      for (int i = 0; i < 16; i++) begin
         @(posedge clk);
         osel <= i[3:0];
         repeat (2) @(posedge clk);
         #1;
         chk("opnd_p", op_p, alt ? 40'h00_0000_0000 : r[i]);
         chk("opnd_s", op_s, alt ? 40'h00_0000_0000 : s[i]);
      end
   endtask
   task automatic set_mode(input logic [31:0] v);
      @(posedge clk);
      mode_we <= 1'b1;
      mode_wd <= v;
      @(posedge clk);
      mode_we <= 1'b0;
      #1;
      chk("mode", mode_rd, mode_wd);
      chk("dual_early", dual, dm);
      dm = v[`SDEC_MODE_DUAL_BIT];
      @(posedge clk);
      #1;
      chk("dual", dual, dm);
   endtask
   task automatic rand_ops(input int n);
      for (int k = 0; k < n; k++) begin
         repeat (5) lf = lfsr(lf);
         sw = lf[15];
         op_do(sw ? 2'h2 : 2'h1, {2'b00, lf[4] & !sw, lf[3:0]},
            {2'b00, lf[9] | sw, lf[8:5]}, lf[10], lf[11], lf[12]);
      end
   endtask
   initial begin
      rst_n = 1'b0;
      mode_we = 1'b0;
      mode_wd = 32'h0000_0000;
      op = 2'h0;
      dst = 7'h00;
      src = 7'h00;
      {ce, cp, cs, mx, mxbg, dm, alt} = 7'h00;
      osel = 4'h0;
      lf = 16'h005d;
      for (int i = 0; i < 128; i++)
         c[i] = {5{i[7:0]}} ^ 40'h5a_a5c3_3c96;
      for (int i = 0; i < 16; i++) begin
         r[i] = 40'h00_0000_0000;
         s[i] = 40'h00_0000_0000;
      end
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      chk("mode_rst", {dual, mode_rd}, 48'h0000_0000_0000);
      for (int i = 0; i < 16; i++) begin
         op_do(2'h1, i[6:0], 7'h60 + i[6:0], 0, 0, 0);
         op_do(2'h1, 7'h10 + i[6:0], 7'h50 + i[6:0], 0, 0, 0);
      end
      verify;
      rand_ops(12);
      op_do(2'h1, 7'h40, 7'h03, 1, 1, 0);
      verify;
      set_mode(32'h0020_0000);
      rand_ops(24);
      verify;
      // alternate banks of both files read as never written, then back
      set_mode(32'h0020_0480);
      alt = 1'b1;
      verify;
      alt = 1'b0;
      set_mode(32'h0020_0000);
      verify;
      for (int k = 0; k < 5; k++)
         op_do(2'h1, 7'h40 + 7'(2 * k), 7'(k), 1, k[0], k[1]);
      op_do(2'h1, 7'h5a, 7'h05, 1, 1, 1);
      op_do(2'h1, 7'h44, 7'h60, 0, 0, 0);
      op_do(2'h1, 7'h02, 7'h44, 0, 0, 0);
      op_do(2'h1, 7'h13, 7'h5b, 0, 0, 0);
      verify;
      for (int k = 0; k < 2; k++) begin
         @(posedge clk);
         mx <= 1'b1;
         mxbg <= k[0];
         @(posedge clk);
         mx <= 1'b0;
         #1;
         chk("mult", mxd, c[7'h7c + k]);
      end
      set_mode(32'h0000_0000);
      rand_ops(6);
      verify;
      test_done;
   end
endmodule // sdec_dual_ctrl_test

// ### sdec_regfile.v
// dual-bank 40-bit data register file for one element
// one explicit and one implicit write port, two registered read ports
`timescale 1ns/10ps
`include "sdec_consts.vh"
module sdec_regfile (
   // clock and reset
   input wire CORE_CLK,
   input wire RST_N,
   // bank select, lower and upper half
   input wire alt_lo,
   input wire alt_hi,
   // write ports
   input wire we_a,
   input wire [3:0] wa_a,
   input wire [`SDEC_DW-1:0] wd_a,
   input wire we_b,
   input wire [3:0] wa_b,
   input wire [`SDEC_DW-1:0] wd_b,
   // read ports
   input wire [3:0] ra_a,
   input wire [3:0] ra_b,
   output reg [`SDEC_DW-1:0] rd_a_ff,
   output reg [`SDEC_DW-1:0] rd_b_ff
);
   reg [`SDEC_DW-1:0] mem [0:31];
   integer i;

   // bank bit: lower eight follow alt_lo, upper eight alt_hi
   function [4:0] phys;
      input [3:0] a;
      input lo;
      input hi;
      begin
         phys = {(a[3] ? hi : lo), a};
      end
   endfunction

   // later port wins on a clash; the mover never aims both at one entry
   always @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         for (i = 0; i < 32; i = i + 1) begin
            mem[i] <= {`SDEC_DW{1'b0}};
         end
         rd_a_ff <= {`SDEC_DW{1'b0}};
         rd_b_ff <= {`SDEC_DW{1'b0}};
      end else begin
         if (we_a) begin
            mem[phys(wa_a, alt_lo, alt_hi)] <= wd_a;
         end
         if (we_b) begin
            mem[phys(wa_b, alt_lo, alt_hi)] <= wd_b;
         end
         rd_a_ff <= mem[phys(ra_a, alt_lo, alt_hi)];
         rd_b_ff <= mem[phys(ra_b, alt_lo, alt_hi)];
      end
   end
endmodule // sdec_regfile
